//--- design/hsp_defs.svh
// Constants of the high-side switch and modulator configuration bank
`ifndef HSP_DEFS_SVH
`define HSP_DEFS_SVH
`define HSP_ADDR_SEL_AB 7'h14
`define HSP_ADDR_SEL_CD 7'h15
`define HSP_ADDR_PIN_CFG 7'h17
`define HSP_ADDR_DUTY_A 7'h18
`define HSP_ADDR_DUTY_B 7'h19
`define HSP_ADDR_RATE 7'h1C
`define HSP_ADDR_SCRATCH 7'h1E
`define HSP_SEL_MASK 8'h77
`define HSP_RATE_MASK 8'h05
`define HSP_RESET_VALUE 8'h00
`define HSP_CLK_HZ 100000000
`define HSP_SLOW_HZ 200
`define HSP_FAST_HZ 400
`define HSP_STEPS 255
// Clock cycles per step at each rate, rounded down
`define HSP_STEP_SLOW ((`HSP_CLK_HZ / `HSP_SLOW_HZ) / `HSP_STEPS)
`define HSP_STEP_FAST ((`HSP_CLK_HZ / `HSP_FAST_HZ) / `HSP_STEPS)
`endif

//--- design/hsp_pkg.sv
// Types of the high-side switch and modulator configuration bank
package hsp_pkg;
   typedef enum logic [2:0] {
      HSP_SRC_OFF = 3'h0,
      HSP_SRC_ON = 3'h1,
      HSP_SRC_TIMER_A = 3'h2,
      HSP_SRC_TIMER_B = 3'h3,
      HSP_SRC_MOD_A = 3'h4,
      HSP_SRC_MOD_B = 3'h5
   } hsp_source_t;
   typedef enum logic [2:0] {
      HSP_PIN_OFF = 3'h4,
      HSP_PIN_WAKE = 3'h5,
      HSP_PIN_LOW_ON = 3'h6,
      HSP_PIN_HIGH_ON = 3'h7
   } hsp_pin_mode_t;
endpackage

//--- design/hsp_modulator.sv
// One duty-cycle modulator with 255 steps per period
`timescale 1ns/10ps
`include "hsp_defs.svh"
module hsp_modulator (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [7:0] duty_in,
   input wire logic fast_in,
   output logic pulse_out
);
   logic [17:0] step_count;
   logic [7:0] phase;
   logic [17:0] step_len;
   assign step_len = fast_in ? 18'(`HSP_STEP_FAST) : 18'(`HSP_STEP_SLOW);
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         step_count <= 18'h0;
         phase <= 8'h0;
      end else if (step_count >= step_len - 18'h1) begin
         step_count <= 18'h0;
         phase <= (phase == 8'(`HSP_STEPS - 1)) ? 8'h0 : phase + 8'h1;
      end else begin
         step_count <= step_count + 18'h1;
      end
   end
   // Zero never fires, 255 always above phase so fully on
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pulse_out <= 1'b0;
      end else begin
         pulse_out <= (phase < duty_in);
      end
   end
   a_duty_zero_off: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (duty_in == 8'h0) [*2] |-> !pulse_out) else $error("pulse high at zero duty");
   a_duty_full_on: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (duty_in == 8'hFF) [*2] |-> pulse_out) else $error("pulse low at full duty");
   a_phase_range: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      phase < 8'hFF) else $error("phase beyond 254");
endmodule // hsp_modulator

//--- design/hsp_config_bank.sv
// Register bank for switch sources, pin setup, modulators and scratch byte
`timescale 1ns/10ps
`include "hsp_defs.svh"
module hsp_config_bank (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic soft_reset_in,
   input wire logic restart_entry_in,
   input wire logic normal_mode_in,
   input wire logic frame_valid_in,
   input wire logic [6:0] frame_addr_in,
   input wire logic frame_write_in,
   input wire logic [7:0] frame_data_in,
   output logic [7:0] frame_rdata_out,
   input wire logic [3:0] fault_in,
   input wire logic timer_a_level_in,
   input wire logic timer_b_level_in,
   output logic [3:0] switch_out,
   output logic [3:0] timer_assigned_out,
   output logic [1:0] fail_output_duty_out,
   output logic [2:0] multipurpose_pin_a_out,
   output logic [2:0] multipurpose_pin_b_out,
   output logic modulator_a_out,
   output logic modulator_b_out
);
   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [7:0] high_side_select_ab;
   logic [7:0] high_side_select_cd;
   logic [7:0] multipurpose_pin_config;
   logic [7:0] pulse_duty_a;
   logic [7:0] pulse_duty_b;
   logic [7:0] pulse_rate_select;
   logic [7:0] host_scratch_byte;
   logic [2:0] field [4];
   logic [3:0] fault_meta;
   logic [3:0] fault_sync;
   logic [1:0] timer_meta;
   logic [1:0] timer_sync;

   function automatic logic wr_hit(input logic [6:0] addr);
      wr_hit = frame_valid_in && frame_write_in && (frame_addr_in == addr);
   endfunction

   function automatic logic src_level(input logic [2:0] sel);
      case (sel)
         hsp_pkg::HSP_SRC_ON: src_level = 1'b1;
         hsp_pkg::HSP_SRC_TIMER_A: src_level = timer_sync[0];
         hsp_pkg::HSP_SRC_TIMER_B: src_level = timer_sync[1];
         hsp_pkg::HSP_SRC_MOD_A: src_level = modulator_a_out;
         hsp_pkg::HSP_SRC_MOD_B: src_level = modulator_b_out;
         default: src_level = 1'b0;
      endcase
   endfunction

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fault_meta <= 4'h0;
         fault_sync <= 4'h0;
         timer_meta <= 2'h0;
         timer_sync <= 2'h0;
      end else begin
         fault_meta <= fault_in;
         fault_sync <= fault_meta;
         timer_meta <= {timer_b_level_in, timer_a_level_in};
         timer_sync <= timer_meta;
      end
   end

   // ----------------------------------------
   // Switch select registers
   // ----------------------------------------
   // Fault clear beats a host write in the same cycle, keeping the switch off
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         high_side_select_ab <= `HSP_RESET_VALUE;
      end else if (soft_reset_in || restart_entry_in) begin
         high_side_select_ab <= `HSP_RESET_VALUE;
      end else begin
         if (wr_hit(`HSP_ADDR_SEL_AB)) begin
            high_side_select_ab <= frame_data_in & `HSP_SEL_MASK;
         end
         if (fault_sync[0]) begin
            high_side_select_ab[2:0] <= 3'h0;
         end
         if (fault_sync[1]) begin
            high_side_select_ab[6:4] <= 3'h0;
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         high_side_select_cd <= `HSP_RESET_VALUE;
      end else if (soft_reset_in || restart_entry_in) begin
         high_side_select_cd <= `HSP_RESET_VALUE;
      end else begin
         if (wr_hit(`HSP_ADDR_SEL_CD)) begin
            high_side_select_cd <= frame_data_in & `HSP_SEL_MASK;
         end
         if (fault_sync[2]) begin
            high_side_select_cd[2:0] <= 3'h0;
         end
         if (fault_sync[3]) begin
            high_side_select_cd[6:4] <= 3'h0;
         end
      end
   end

   // ----------------------------------------
   // Pin, duty and rate registers
   // ----------------------------------------
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         multipurpose_pin_config <= `HSP_RESET_VALUE;
         pulse_duty_a <= `HSP_RESET_VALUE;
         pulse_duty_b <= `HSP_RESET_VALUE;
      end else if (soft_reset_in) begin
         multipurpose_pin_config <= `HSP_RESET_VALUE;
         pulse_duty_a <= `HSP_RESET_VALUE;
         pulse_duty_b <= `HSP_RESET_VALUE;
      end else begin
         if (wr_hit(`HSP_ADDR_PIN_CFG)) begin
            multipurpose_pin_config <= frame_data_in;
         end
         if (wr_hit(`HSP_ADDR_DUTY_A)) begin
            pulse_duty_a <= frame_data_in;
         end
         if (wr_hit(`HSP_ADDR_DUTY_B)) begin
            pulse_duty_b <= frame_data_in;
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pulse_rate_select <= `HSP_RESET_VALUE;
      end else if (soft_reset_in) begin
         pulse_rate_select <= `HSP_RESET_VALUE;
      end else if (wr_hit(`HSP_ADDR_RATE)) begin
         pulse_rate_select <= frame_data_in & `HSP_RATE_MASK;
      end
   end

   // ----------------------------------------
   // Scratch byte
   // ----------------------------------------
   // Only the power-on reset reaches it; soft reset and restart do not
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         host_scratch_byte <= `HSP_RESET_VALUE;
      end else if (wr_hit(`HSP_ADDR_SCRATCH) && normal_mode_in) begin
         host_scratch_byte <= frame_data_in;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         frame_rdata_out <= 8'h00;
      end else if (frame_valid_in) begin
         case (frame_addr_in)
            `HSP_ADDR_SEL_AB: frame_rdata_out <= high_side_select_ab;
            `HSP_ADDR_SEL_CD: frame_rdata_out <= high_side_select_cd;
            `HSP_ADDR_PIN_CFG: frame_rdata_out <= multipurpose_pin_config;
            `HSP_ADDR_DUTY_A: frame_rdata_out <= pulse_duty_a;
            `HSP_ADDR_DUTY_B: frame_rdata_out <= pulse_duty_b;
            `HSP_ADDR_RATE: frame_rdata_out <= pulse_rate_select;
            `HSP_ADDR_SCRATCH: frame_rdata_out <= normal_mode_in ? host_scratch_byte : 8'h00;
            default: frame_rdata_out <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // Modulators and switch drive
   // ----------------------------------------
   hsp_modulator u_modulator_a (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .duty_in(pulse_duty_a),
      .fast_in(pulse_rate_select[0]),
      .pulse_out(modulator_a_out)
   );
   hsp_modulator u_modulator_b (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .duty_in(pulse_duty_b),
      .fast_in(pulse_rate_select[2]),
      .pulse_out(modulator_b_out)
   );

   assign field[0] = high_side_select_ab[2:0];
   assign field[1] = high_side_select_ab[6:4];
   assign field[2] = high_side_select_cd[2:0];
   assign field[3] = high_side_select_cd[6:4];

   // Timer engine outside starts once assigned, then on-time set
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         timer_assigned_out[i] = (field[i] == hsp_pkg::HSP_SRC_TIMER_A)
            || (field[i] == hsp_pkg::HSP_SRC_TIMER_B);
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         switch_out <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            switch_out[i] <= src_level(field[i]);
         end
      end
   end

   assign fail_output_duty_out = multipurpose_pin_config[7:6];
   assign multipurpose_pin_a_out = multipurpose_pin_config[2:0];
   assign multipurpose_pin_b_out = multipurpose_pin_config[5:3];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_fault_clears_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      fault_sync[0] && !soft_reset_in |=> high_side_select_ab[2:0] == 3'h0)
      else $error("switch a select not cleared by fault");
   a_restart_clears_sel: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      restart_entry_in |=> high_side_select_ab == 8'h00 && high_side_select_cd == 8'h00)
      else $error("select not cleared on restart");
   a_restart_keeps_cfg: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      restart_entry_in && !soft_reset_in && !frame_valid_in |=> $stable(pulse_duty_a)
      && $stable(multipurpose_pin_config) && $stable(pulse_rate_select))
      else $error("config lost on restart");
   a_soft_keeps_scratch: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      soft_reset_in && !frame_valid_in |=> $stable(host_scratch_byte))
      else $error("scratch lost on soft reset");
   a_scratch_mode_gate: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      !normal_mode_in |=> $stable(host_scratch_byte))
      else $error("scratch written outside normal mode");
   a_reserved_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (high_side_select_ab & 8'h88) == 8'h00 && (pulse_rate_select & 8'hFA) == 8'h00)
      else $error("reserved bit set");
   a_switch_on_src: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      field[0] == hsp_pkg::HSP_SRC_ON |=> switch_out[0] || fault_sync[0])
      else $error("switch a not on");
   a_switch_off_src: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      field[3] == hsp_pkg::HSP_SRC_OFF |=> !switch_out[3])
      else $error("switch d not off");
endmodule // hsp_config_bank

//--- verification/hsp_host_model.sv
// Host side of the command interface, one frame per call
`timescale 1ns/10ps
module hsp_host_model (
   input wire logic clock_in,
   output logic frame_valid_out,
   output logic [6:0] frame_addr_out,
   output logic frame_write_out,
   output logic [7:0] frame_data_out,
   input wire logic [7:0] frame_rdata_in
);
   // -------------------------------------------------
   // Frame issue
   // -------------------------------------------------
   initial begin
      frame_valid_out = 1'b0;
      frame_addr_out = 7'h00;
      frame_write_out = 1'b0;
      frame_data_out = 8'h00;
   end
   // Address, access bit and data byte move as one unit
   task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                       output logic [7:0] r);
      @(negedge clock_in);
      frame_valid_out = 1'b1;
      frame_addr_out = a;
      frame_write_out = wr;
      frame_data_out = d;
      @(negedge clock_in);
      frame_valid_out = 1'b0;
      // Idle lines show the inverse, not a stale frame
      frame_addr_out = ~a;
      frame_write_out = ~wr;
      frame_data_out = ~d;
      @(negedge clock_in);
      r = frame_rdata_in;
   endtask
endmodule // hsp_host_model

//--- verification/high_side_switch_pwm_config_bench.sv
// Bench: register bank and switch drive against a behavioural model
`timescale 1ns/10ps
module high_side_switch_pwm_config_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic soft_rst = 1'b0;
   logic restart = 1'b0;
   logic normal = 1'b1;
   logic fv, fw, ma, mb;
   logic [6:0] fa;
   logic [7:0] fd, rdat, got, v;
   logic [3:0] fault = 4'h0;
   logic tma = 1'b0;
   logic tmb = 1'b0;
   logic [3:0] sw, tas;
   logic [1:0] fod;
   logic [2:0] pa, pb;
   logic [7:0] mreg [0:127];
   logic [6:0] addrs [0:6] = '{7'h14, 7'h15, 7'h17, 7'h18, 7'h19, 7'h1C, 7'h1E};
   logic [31:0] seed = 32'hB087A1BF;
   int n_errors = 0;
   int cmp_count = 0;
   int k, fall_a, fall_b;
   int cyc = 0;
   logic exp_sw, exp_tas;
   logic [1:0] hi;
   always #5 clk = ~clk;
   // Edges since the last reset release, to time the modulator steps
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) cyc <= 0;
      else cyc <= cyc + 1;
   end
   hsp_host_model host (.clock_in(clk), .frame_valid_out(fv), .frame_addr_out(fa),
      .frame_write_out(fw), .frame_data_out(fd), .frame_rdata_in(rdat));
   hsp_config_bank DUT (.clock_in(clk), .rst_n_in(rst_n), .soft_reset_in(soft_rst),
      .restart_entry_in(restart), .normal_mode_in(normal), .frame_valid_in(fv),
      .frame_addr_in(fa), .frame_write_in(fw), .frame_data_in(fd),
      .frame_rdata_out(rdat), .fault_in(fault), .timer_a_level_in(tma),
      .timer_b_level_in(tmb), .switch_out(sw), .timer_assigned_out(tas),
      .fail_output_duty_out(fod), .multipurpose_pin_a_out(pa),
      .multipurpose_pin_b_out(pb), .modulator_a_out(ma), .modulator_b_out(mb));
   // -------------------------------------------------
   // Model and tasks
   // -------------------------------------------------
   function automatic logic [7:0] mask(input logic [6:0] a);
      case (a)
         7'h14, 7'h15: return 8'h77;
         7'h17, 7'h18, 7'h19, 7'h1E: return 8'hFF;
         7'h1C: return 8'h05;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic check(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic check_cyc(input int g, input int e);
      cmp_count++;
      if (g != e) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, got);
      if (mask(a) != 8'h00 && (a != 7'h1E || normal))
         mreg[a] = d & mask(a);
   endtask
   task automatic rd_chk(input logic [6:0] a);
      host.xfer(1'b0, a, 8'h00, got);
      check(got, (a == 7'h1E && !normal) ? 8'h00 : mreg[a]);
   endtask
   task automatic fill();
      foreach (addrs[i]) begin
         v = rnd();
         // Host keeps off the unrealisable duty of one
         if (addrs[i] inside {7'h18, 7'h19} && v == 8'h01)
            v = 8'h02;
         wr(addrs[i], v);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task automatic tally_and_finish();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // -------------------------------------------------
   // Scenarios
   // -------------------------------------------------
   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      tally_and_finish();
   end
   initial begin
      foreach (mreg[i]) mreg[i] = 8'h00;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      foreach (addrs[i]) rd_chk(addrs[i]);
      repeat (3) begin
         fill();
         foreach (addrs[i]) rd_chk(addrs[i]);
      end
      rd_chk(7'h16);
      for (int c = 0; c < 8; c++) begin
         wr(7'h17, {c[1:0], ~c[2:0], c[2:0]});
         check({6'h00, fod}, {6'h00, c[1:0]});
         check({5'h00, pa}, {5'h00, c[2:0]});
         check({5'h00, pb}, {5'h00, ~c[2:0]});
      end
      // Scratch refused outside normal mode
      normal = 1'b0;
      wr(7'h1E, 8'hA5);
      rd_chk(7'h1E);
      normal = 1'b1;
      rd_chk(7'h1E);
      pulse(soft_rst);
      foreach (addrs[i]) if (addrs[i] != 7'h1E) mreg[addrs[i]] = 8'h00;
      foreach (addrs[i]) rd_chk(addrs[i]);
      fill();
      pulse(restart);
      mreg[7'h14] = 8'h00;
      mreg[7'h15] = 8'h00;
      foreach (addrs[i]) rd_chk(addrs[i]);
      // Drive source per code; duty all ones is full on, zero full off
      wr(7'h18, 8'hFF);
      wr(7'h19, 8'h00);
      // Each source code in turn with only one timer level high
      for (int c = 0; c < 12; c++) begin
         k = c % 6;
         tma = (c < 6);
         tmb = (c >= 6);
         exp_sw = (k == 1) || (k == 4) || (k == 2 && tma) || (k == 3 && tmb);
         exp_tas = (k == 2) || (k == 3);
         wr(7'h14, {1'b0, 3'(k), 1'b0, 3'(k)});
         repeat (8) @(negedge clk);
         check({7'h00, sw[0]}, {7'h00, exp_sw});
         check({5'h00, sw[3:1]}, {7'h00, exp_sw});
         check({4'h0, tas}, {6'h00, exp_tas, exp_tas});
      end
      check({6'h00, ma, mb}, 8'h02);
      // Fault clears only the faulty switch field
      wr(7'h15, 8'h11);
      fault = 4'h5;
      repeat (6) @(negedge clk);
      fault = 4'h0;
      mreg[7'h14] = 8'h50;
      mreg[7'h15] = 8'h10;
      rd_chk(7'h14);
      rd_chk(7'h15);
      check({4'h0, sw}, 8'h08);
      // Power-on reset in mid run also clears the scratch byte
      wr(7'h1E, 8'h3C);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      foreach (addrs[i]) mreg[addrs[i]] = 8'h00;
      foreach (addrs[i]) rd_chk(addrs[i]);
      // Duty two at each rate; both periods restart at reset release
      wr(7'h1C, 8'h01);
      wr(7'h18, 8'h02);
      wr(7'h19, 8'h02);
      hi = 2'b00;
      fall_a = 0;
      fall_b = 0;
      for (int n = 0; n < 5000 && fall_b == 0; n++) begin
         @(negedge clk);
         if (hi[0] && !ma && fall_a == 0) fall_a = cyc;
         if (hi[1] && !mb && fall_b == 0) fall_b = cyc;
         hi = hi | {mb, ma};
      end
      check_cyc(fall_a, 2 * (100000000 / 400 / 255) + 1);
      check_cyc(fall_b, 2 * (100000000 / 200 / 255) + 1);
      tally_and_finish();
   end
endmodule // high_side_switch_pwm_config_bench
